/* rtl/cpu_state_pkg.sv */
package cpu_state_pkg;
    // status word field positions
    localparam int unsigned flag_lsb = 0;
    localparam int unsigned ie_bit = 16;
    localparam int unsigned ss_bit = 17;
    localparam int unsigned pm_bit = 20;
    localparam int unsigned mask_lsb = 24;
    localparam logic [3:0] mask_all = 4'hf;
    // values after reset
    localparam logic [3:0] flags_rst = 4'h0;
    localparam logic [3:0] mask_rst = 4'h0;
    localparam logic ie_rst = 1'b0;
    localparam logic ss_rst = 1'b0;
    localparam logic pm_rst = 1'b0;
    localparam logic [31:0] word_rst = 32'h0000_0000;
    localparam logic [63:0] sum_rd_rst = 64'h0;

    typedef enum logic [3:0] {
        op_none = 4'h0,
        op_wr_status = 4'h1,
        op_wr_ctrl = 4'h2,
        op_set_mask = 4'h3,
        op_exc_return = 4'h4,
        op_fast_return = 4'h5,
        op_wait = 4'h6,
        op_sum_write_high = 4'h7,
        op_sum_write_low = 4'h8,
        op_sum_read_high = 4'h9,
        op_sum_read_middle = 4'ha,
        op_multiply = 4'hb
    } op_e;

    typedef enum logic [2:0] {
        ctrl_isp = 3'h0,
        ctrl_usp = 3'h1,
        ctrl_vector_base_reg = 3'h2,
        ctrl_bpc = 3'h3,
        ctrl_fast_saved_status = 3'h4,
        ctrl_fast_irq_vector = 3'h5
    } ctrl_e;

    typedef enum logic [1:0] {
        cause_none = 2'h0,
        cause_nmi = 2'h1,
        cause_sync = 2'h2,
        cause_irq = 2'h3
    } cause_e;

    // assemble a status word, reserved bits zero
    function automatic logic [31:0] pack_status(input logic [3:0] flags, input logic ie, input logic ss,
                                                input logic pm, input logic [3:0] mask);
        logic [31:0] w;
        w = 32'h0;
        w[flag_lsb +: 4] = flags;
        w[ie_bit] = ie;
        w[ss_bit] = ss;
        w[pm_bit] = pm;
        w[mask_lsb +: 4] = mask;
        return w;
    endfunction : pack_status

    // reverse byte lanes
    function automatic logic [31:0] swap_lanes(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swap_lanes
endpackage : cpu_state_pkg

/* rtl/dsp_sum_unit.sv */
`timescale 1ns/1ps
module dsp_sum_unit #(
    parameter int unsigned width = 64
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic write_high,
    input wire logic write_low,
    input wire logic mul_write,
    input wire logic read_high,
    input wire logic read_middle,
    input wire logic [31:0] wr_data,
    input wire logic [width-1:0] mul_value,
    output logic [31:0] rd_data,
    output logic rd_valid
);
    // accumulator itself has no reset
    logic [width-1:0] dsp_sum_register;
    logic [width-1:0] next_sum;
    logic [31:0] next_rd_data;
    logic next_rd_valid;

    always_comb begin
        next_sum = dsp_sum_register;
        if (mul_write) begin
            next_sum = mul_value;
        end else begin
            if (write_high) begin
                next_sum[63:32] = wr_data;
            end
            if (write_low) begin
                next_sum[31:0] = wr_data;
            end
        end
    end

    always_comb begin
        next_rd_valid = read_high || read_middle;
        next_rd_data = rd_data;
        if (read_high) begin
            next_rd_data = dsp_sum_register[63:32];
        end else if (read_middle) begin
            next_rd_data = dsp_sum_register[47:16];
        end
    end

    always_ff @(posedge mclk) begin
        dsp_sum_register <= next_sum;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_data <= cpu_state_pkg::word_rst;
            rd_valid <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end
endmodule : dsp_sum_unit

/* rtl/lane_steer.sv */
`timescale 1ns/1ps
module lane_steer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic endian_big,
    input wire logic ld_valid,
    input wire logic [31:0] ld_mem_bytes,
    input wire logic st_valid,
    input wire logic [31:0] st_reg,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_mem_bytes,
    output logic [31:0] ld_reg,
    output logic ld_done,
    output logic [31:0] st_mem_bytes,
    output logic st_done,
    output logic [31:0] fetch_word,
    output logic fetch_done
);
    // memory byte k (address A+k) sits in bits 8k+7..8k
    logic [31:0] next_ld_reg;
    logic [31:0] next_st_mem;
    logic [31:0] next_fetch;

    always_comb begin
        next_ld_reg = ld_valid ? (endian_big ? cpu_state_pkg::swap_lanes(ld_mem_bytes)
                                             : ld_mem_bytes) : ld_reg;
        next_st_mem = st_valid ? (endian_big ? cpu_state_pkg::swap_lanes(st_reg)
                                             : st_reg) : st_mem_bytes;
        next_fetch = fetch_valid ? fetch_mem_bytes : fetch_word;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ld_reg <= cpu_state_pkg::word_rst;
            st_mem_bytes <= cpu_state_pkg::word_rst;
            fetch_word <= cpu_state_pkg::word_rst;
            ld_done <= 1'b0;
            st_done <= 1'b0;
            fetch_done <= 1'b0;
        end else begin
            ld_reg <= next_ld_reg;
            st_mem_bytes <= next_st_mem;
            fetch_word <= next_fetch;
            ld_done <= ld_valid;
            st_done <= st_valid;
            fetch_done <= fetch_valid;
        end
    end
endmodule : lane_steer

/* rtl/cpu_mode_status_endian.sv */
`timescale 1ns/1ps
module cpu_mode_status_endian (
    input wire logic mclk,
    input wire logic rst,
    input wire logic endian_strap,
    input wire logic [31:0] pc,
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic [2:0] op_ctrl_sel,
    input wire logic [31:0] op_data,
    input wire logic [63:0] mul_value,
    input wire logic [3:0] next_flags_in,
    input wire logic flags_update,
    input wire logic sync_exc_req,
    input wire logic nmi_req,
    input wire logic irq_req,
    input wire logic [3:0] irq_prio,
    input wire logic irq_fast,
    input wire logic ld_valid,
    input wire logic [31:0] ld_mem_bytes,
    input wire logic st_valid,
    input wire logic [31:0] st_reg,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_mem_bytes,
    output logic op_done,
    output logic nmi_ack,
    output logic irq_ack,
    output logic priv_fault,
    output logic [31:0] status_word,
    output logic [31:0] active_sp,
    output logic [31:0] irq_stack_ptr,
    output logic [31:0] app_stack_ptr,
    output logic [31:0] vector_base_reg,
    output logic [31:0] fast_saved_pc,
    output logic [31:0] fast_saved_status,
    output logic [31:0] fast_irq_vector,
    output logic waiting,
    output logic endian_big,
    output logic exc_taken,
    output logic [1:0] exc_cause,
    output logic [31:0] exc_saved_status,
    output logic branch_valid,
    output logic [31:0] branch_addr,
    output logic [31:0] sum_rd_data,
    output logic sum_rd_valid,
    output logic [31:0] ld_reg,
    output logic ld_done,
    output logic [31:0] st_mem_bytes,
    output logic st_done,
    output logic [31:0] fetch_word,
    output logic fetch_done
);
    logic [3:0] flags, next_flags;
    logic ie, next_ie;
    logic ss, next_ss;
    logic pm, next_pm;
    logic [3:0] cpu_priority_mask, next_mask;
    logic [31:0] next_isp, next_usp, next_vector_base_reg, next_bpc, next_fast_saved_status, next_fast_irq_vector;
    logic next_waiting;
    logic next_exc_taken;
    logic [1:0] next_exc_cause;
    logic [31:0] next_exc_saved;
    logic next_branch_valid;
    logic [31:0] next_branch_addr;
    logic processor_mode_bit;
    logic priv_op;
    logic sync_take;
    logic any_take;
    logic go;
    cpu_state_pkg::op_e op;
    cpu_state_pkg::ctrl_e csel;

    assign op = cpu_state_pkg::op_e'(op_code);
    assign csel = cpu_state_pkg::ctrl_e'(op_ctrl_sel);
    assign processor_mode_bit = pm;
    assign status_word = cpu_state_pkg::pack_status(flags, ie, ss, pm, cpu_priority_mask);
    assign active_sp = ss ? app_stack_ptr : irq_stack_ptr;

    // acceptance: nmi, then synchronous faults, then maskable interrupts
    always_comb begin
        priv_op = op_valid && (op == cpu_state_pkg::op_set_mask || op == cpu_state_pkg::op_exc_return
                               || op == cpu_state_pkg::op_fast_return || op == cpu_state_pkg::op_wait);
        priv_fault = priv_op && processor_mode_bit && !nmi_req;
        nmi_ack = nmi_req;
        sync_take = !nmi_req && (priv_fault || sync_exc_req);
        irq_ack = !nmi_req && !sync_take && irq_req && ie && (irq_prio > cpu_priority_mask);
        any_take = nmi_ack || sync_take || irq_ack;
        go = op_valid && !any_take;
        op_done = go;
    end

    always_comb begin
        next_flags = flags;
        next_ie = ie;
        next_ss = ss;
        next_pm = pm;
        next_mask = cpu_priority_mask;
        next_isp = irq_stack_ptr;
        next_usp = app_stack_ptr;
        next_vector_base_reg = vector_base_reg;
        next_bpc = fast_saved_pc;
        next_fast_saved_status = fast_saved_status;
        next_fast_irq_vector = fast_irq_vector;
        next_waiting = waiting;
        next_exc_taken = 1'b0;
        next_exc_cause = cpu_state_pkg::cause_none;
        next_exc_saved = exc_saved_status;
        next_branch_valid = 1'b0;
        next_branch_addr = branch_addr;
        if (flags_update) begin
            next_flags = next_flags_in;
        end
        if (any_take) begin
            next_exc_taken = 1'b1;
            next_exc_saved = status_word;
            next_pm = 1'b0;
            next_ss = 1'b0;
            next_ie = 1'b0;
            next_waiting = 1'b0;
            if (nmi_ack) begin
                next_exc_cause = cpu_state_pkg::cause_nmi;
                next_mask = cpu_state_pkg::mask_all;
            end else if (sync_take) begin
                next_exc_cause = cpu_state_pkg::cause_sync;
            end else begin
                next_exc_cause = cpu_state_pkg::cause_irq;
                next_mask = irq_prio;
                if (irq_fast) begin
                    next_bpc = pc;
                    next_fast_saved_status = status_word;
                    next_branch_valid = 1'b1;
                    next_branch_addr = fast_irq_vector;
                end
            end
        end else if (go) begin
            unique case (op)
                cpu_state_pkg::op_wr_status: begin
                    next_flags = op_data[cpu_state_pkg::flag_lsb +: 4];
                    if (!processor_mode_bit) begin
                        next_ie = op_data[cpu_state_pkg::ie_bit];
                        next_ss = op_data[cpu_state_pkg::ss_bit];
                        next_mask = op_data[cpu_state_pkg::mask_lsb +: 4];
                    end
                end
                cpu_state_pkg::op_wr_ctrl: begin
                    if (csel == cpu_state_pkg::ctrl_usp) begin
                        next_usp = op_data;
                    end else if (!processor_mode_bit) begin
                        unique case (csel)
                            cpu_state_pkg::ctrl_isp: next_isp = op_data;
                            cpu_state_pkg::ctrl_vector_base_reg: next_vector_base_reg = op_data;
                            cpu_state_pkg::ctrl_bpc: next_bpc = op_data;
                            cpu_state_pkg::ctrl_fast_saved_status: next_fast_saved_status = cpu_state_pkg::pack_status(
                                op_data[3:0], op_data[16], op_data[17], op_data[20], op_data[27:24]);
                            cpu_state_pkg::ctrl_fast_irq_vector: next_fast_irq_vector = op_data;
                            default: next_fast_irq_vector = fast_irq_vector;
                        endcase
                    end
                end
                cpu_state_pkg::op_set_mask: next_mask = op_data[3:0];
                cpu_state_pkg::op_exc_return: begin
                    next_flags = op_data[cpu_state_pkg::flag_lsb +: 4];
                    next_ie = op_data[cpu_state_pkg::ie_bit];
                    next_ss = op_data[cpu_state_pkg::ss_bit];
                    next_pm = op_data[cpu_state_pkg::pm_bit];
                    next_mask = op_data[cpu_state_pkg::mask_lsb +: 4];
                end
                cpu_state_pkg::op_fast_return: begin
                    next_flags = fast_saved_status[cpu_state_pkg::flag_lsb +: 4];
                    next_ie = fast_saved_status[cpu_state_pkg::ie_bit];
                    next_ss = fast_saved_status[cpu_state_pkg::ss_bit];
                    next_pm = fast_saved_status[cpu_state_pkg::pm_bit];
                    next_mask = fast_saved_status[cpu_state_pkg::mask_lsb +: 4];
                    next_branch_valid = 1'b1;
                    next_branch_addr = fast_saved_pc;
                end
                cpu_state_pkg::op_wait: next_waiting = 1'b1;
                default: next_waiting = waiting;
            endcase
            if (!pm && next_pm) begin
                next_ss = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            flags <= cpu_state_pkg::flags_rst;
            ie <= cpu_state_pkg::ie_rst;
            ss <= cpu_state_pkg::ss_rst;
            pm <= cpu_state_pkg::pm_rst;
            cpu_priority_mask <= cpu_state_pkg::mask_rst;
            irq_stack_ptr <= cpu_state_pkg::word_rst;
            app_stack_ptr <= cpu_state_pkg::word_rst;
            vector_base_reg <= cpu_state_pkg::word_rst;
            fast_saved_pc <= cpu_state_pkg::word_rst;
            fast_saved_status <= cpu_state_pkg::word_rst;
            fast_irq_vector <= cpu_state_pkg::word_rst;
            waiting <= 1'b0;
            exc_taken <= 1'b0;
            exc_cause <= cpu_state_pkg::cause_none;
            exc_saved_status <= cpu_state_pkg::word_rst;
            branch_valid <= 1'b0;
            branch_addr <= cpu_state_pkg::word_rst;
        end else begin
            flags <= next_flags;
            ie <= next_ie;
            ss <= next_ss;
            pm <= next_pm;
            cpu_priority_mask <= next_mask;
            irq_stack_ptr <= next_isp;
            app_stack_ptr <= next_usp;
            vector_base_reg <= next_vector_base_reg;
            fast_saved_pc <= next_bpc;
            fast_saved_status <= next_fast_saved_status;
            fast_irq_vector <= next_fast_irq_vector;
            waiting <= next_waiting;
            exc_taken <= next_exc_taken;
            exc_cause <= next_exc_cause;
            exc_saved_status <= next_exc_saved;
            branch_valid <= next_branch_valid;
            branch_addr <= next_branch_addr;
        end
    end

    // endian strap held while reset is asserted, frozen after release
    logic next_endian;
    always_comb begin
        next_endian = rst ? endian_strap : endian_big;
    end
    always_ff @(posedge mclk) begin
        endian_big <= next_endian;
    end

    dsp_sum_unit #(.width(64)) u_sum (
        .mclk(mclk),
        .rst(rst),
        .write_high(go && op == cpu_state_pkg::op_sum_write_high),
        .write_low(go && op == cpu_state_pkg::op_sum_write_low),
        .mul_write(go && op == cpu_state_pkg::op_multiply),
        .read_high(go && op == cpu_state_pkg::op_sum_read_high),
        .read_middle(go && op == cpu_state_pkg::op_sum_read_middle),
        .wr_data(op_data),
        .mul_value(mul_value),
        .rd_data(sum_rd_data),
        .rd_valid(sum_rd_valid)
    );

    lane_steer u_lanes (
        .mclk(mclk),
        .rst(rst),
        .endian_big(endian_big),
        .ld_valid(ld_valid),
        .ld_mem_bytes(ld_mem_bytes),
        .st_valid(st_valid),
        .st_reg(st_reg),
        .fetch_valid(fetch_valid),
        .fetch_mem_bytes(fetch_mem_bytes),
        .ld_reg(ld_reg),
        .ld_done(ld_done),
        .st_mem_bytes(st_mem_bytes),
        .st_done(st_done),
        .fetch_word(fetch_word),
        .fetch_done(fetch_done)
    );
endmodule : cpu_mode_status_endian

/* dv/cpu_mode_status_endian_asserts.sv */
`timescale 1ns/1ps
module cpu_mode_status_endian_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic op_done,
    input wire logic [31:0] pc,
    input wire logic [3:0] irq_prio,
    input wire logic irq_fast,
    input wire logic nmi_ack,
    input wire logic irq_ack,
    input wire logic priv_fault,
    input wire logic [31:0] status_word,
    input wire logic [31:0] fast_saved_pc,
    input wire logic [31:0] fast_saved_status,
    input wire logic [31:0] fast_irq_vector,
    input wire logic endian_big,
    input wire logic exc_taken,
    input wire logic branch_valid,
    input wire logic [31:0] branch_addr,
    input wire logic ld_valid,
    input wire logic [31:0] ld_mem_bytes,
    input wire logic [31:0] ld_reg,
    input wire logic ld_done
);
    logic [31:0] ld_back;
    assign ld_back = endian_big ? {ld_reg[7:0], ld_reg[15:8], ld_reg[23:16], ld_reg[31:24]} : ld_reg;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_exc_clear;
        exc_taken |-> status_word[17:16] == 2'b00 && !status_word[20];
    endproperty
    a_exc_clear: assert property (p_exc_clear) else $error("exception left mode bits set");
    property p_nmi_mask;
        nmi_ack |=> status_word[27:24] == 4'hf;
    endproperty
    a_nmi_mask: assert property (p_nmi_mask) else $error("nmi did not force mask");
    property p_irq_mask;
        irq_ack |=> status_word[27:24] == $past(irq_prio);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("mask not loaded with level");
    property p_irq_gate;
        irq_ack |-> status_word[16] && irq_prio > status_word[27:24];
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt accepted when gated");
    property p_priv;
        op_valid && status_word[20] && op_code inside {4'h3, 4'h4, 4'h5, 4'h6} |-> priv_fault && !op_done;
    endproperty
    a_priv: assert property (p_priv) else $error("privileged op ran in user mode");
    property p_user_ss;
        $rose(status_word[20]) |-> status_word[17];
    endproperty
    a_user_ss: assert property (p_user_ss) else $error("user entry without app stack");
    property p_fast_save;
        irq_ack && irq_fast |=> fast_saved_pc == $past(pc) && fast_saved_status == $past(status_word)
            && branch_valid && branch_addr == $past(fast_irq_vector);
    endproperty
    a_fast_save: assert property (p_fast_save) else $error("fast entry save or branch wrong");
    property p_reserved;
        (status_word & 32'hf0ec_fff0) == 32'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bit set");
    property p_sup_pm;
        op_done && op_code == 4'h1 && !status_word[20] |=> !status_word[20];
    endproperty
    a_sup_pm: assert property (p_sup_pm) else $error("supervisor write changed mode");
    property p_lane;
        ld_valid |=> ld_done && ld_back == $past(ld_mem_bytes);
    endproperty
    a_lane: assert property (p_lane) else $error("load lanes wrong");
    c_nmi: cover property (nmi_ack);
    c_fast: cover property (irq_ack && irq_fast);
    c_priv: cover property (priv_fault);
endmodule : cpu_mode_status_endian_asserts

bind cpu_mode_status_endian cpu_mode_status_endian_asserts i_chk (.*);

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0, rst = 1'b1, endian_strap = 1'b0, op_valid = 1'b0, flags_update = 1'b0;
    logic sync_exc_req = 1'b0, nmi_req = 1'b0, irq_req = 1'b0, irq_fast = 1'b0;
    logic ld_valid = 1'b0, st_valid = 1'b0, fetch_valid = 1'b0;
    logic [3:0] op_code = 4'h0, next_flags_in = 4'h0, irq_prio = 4'h0;
    logic [2:0] op_ctrl_sel = 3'h0;
    logic [31:0] pc = 32'h0, op_data = 32'h0, ld_mem_bytes = 32'h0, st_reg = 32'h0, fetch_mem_bytes = 32'h0;
    logic [63:0] mul_value = 64'h0;
    logic op_done, nmi_ack, irq_ack, priv_fault, waiting, endian_big, exc_taken, branch_valid;
    logic sum_rd_valid, ld_done, st_done, fetch_done;
    logic [1:0] exc_cause;
    logic [31:0] status_word, active_sp, irq_stack_ptr, app_stack_ptr, vector_base_reg, fast_saved_pc;
    logic [31:0] fast_saved_status, fast_irq_vector, exc_saved_status, branch_addr, sum_rd_data;
    logic [31:0] ld_reg, st_mem_bytes, fetch_word;
    logic [31:0] lfsr = 32'h3b41;
    int n_fail = 0;
    int num_checks = 0;
    cpu_mode_status_endian i_dut (.*);
    always #2 mclk = ~mclk;
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c1_1db7 : 32'h0);
        return lfsr;
    endfunction : rnd
    function automatic logic [31:0] swp(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swp
    function automatic logic [31:0] sw(input logic [3:0] m, input logic pm, ss, ie, input logic [3:0] fl);
        return {4'h0, m, 3'h0, pm, 2'h0, ss, ie, 12'h0, fl};
    endfunction : sw
    task automatic step();
        @(posedge mclk);
        #1;
    endtask : step
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk32
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk1
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic op(input cpu_state_pkg::op_e c, input cpu_state_pkg::ctrl_e s, input logic [31:0] d);
        // valid left high, next driver lowers it
        irq_req = 1'b0;
        op_valid = 1'b1;
        op_code = c;
        op_ctrl_sel = s;
        op_data = d;
        step();
    endtask : op
    task automatic irq(input logic [3:0] p, input logic f, input logic ack);
        op_valid = 1'b0;
        irq_req = 1'b1;
        irq_prio = p;
        irq_fast = f;
        #1;
        chk1(irq_ack, ack);
        step();
    endtask : irq
    task automatic do_reset(input logic big);
        rst = 1'b1;
        op_valid = 1'b0;
        endian_strap = big;
        repeat (12) step();
        rst = 1'b0;
        chk32(status_word, 32'h0);
        endian_strap = ~big;
    endtask : do_reset
    task automatic lanes(input logic big);
        logic [31:0] b, r;
        ld_valid = 1'b1;
        st_valid = 1'b1;
        fetch_valid = 1'b1;
        for (int i = 0; i < 8; i++) begin
            b = rnd();
            r = rnd();
            ld_mem_bytes = b;
            fetch_mem_bytes = b;
            st_reg = r;
            step();
            chk32(ld_reg, big ? swp(b) : b);
            chk32(st_mem_bytes, big ? swp(r) : r);
            chk32(fetch_word, b);
            chk1(ld_done & st_done & fetch_done, 1'b1);
        end
        ld_valid = 1'b0;
        st_valid = 1'b0;
        fetch_valid = 1'b0;
        chk1(endian_big, big);
    endtask : lanes
    initial begin
        logic [31:0] a, b, v;
        logic [63:0] m;
        cpu_state_pkg::op_e pr [4];
        pr = '{cpu_state_pkg::op_set_mask, cpu_state_pkg::op_exc_return,
               cpu_state_pkg::op_fast_return, cpu_state_pkg::op_wait};
        do_reset(1'b0);
        lanes(1'b0);
        for (int i = 0; i < 4; i++) begin
            a = rnd();
            b = rnd();
            op(cpu_state_pkg::op_sum_write_high, cpu_state_pkg::ctrl_isp, a);
            op(cpu_state_pkg::op_sum_write_low, cpu_state_pkg::ctrl_isp, b);
            op(cpu_state_pkg::op_sum_read_high, cpu_state_pkg::ctrl_isp, 32'h0);
            chk32(sum_rd_data, a);
            op(cpu_state_pkg::op_sum_read_middle, cpu_state_pkg::ctrl_isp, 32'h0);
            chk32(sum_rd_data, {a[15:0], b[31:16]});
            chk1(sum_rd_valid, 1'b1);
        end
        m = {rnd(), rnd()};
        mul_value = m;
        op(cpu_state_pkg::op_multiply, cpu_state_pkg::ctrl_isp, 32'h0);
        op(cpu_state_pkg::op_sum_read_middle, cpu_state_pkg::ctrl_isp, 32'h0);
        chk32(sum_rd_data, m[47:16]);
        op(cpu_state_pkg::op_wr_status, cpu_state_pkg::ctrl_isp, 32'h0311_000a);
        chk32(status_word, sw(4'h3, 1'b0, 1'b0, 1'b1, 4'ha));
        irq(4'h3, 1'b0, 1'b0);
        irq(4'h4, 1'b0, 1'b1);
        chk32(status_word, sw(4'h4, 1'b0, 1'b0, 1'b0, 4'ha));
        chk32({30'h0, exc_cause}, 32'h3);
        irq(4'hf, 1'b0, 1'b0);
        op(cpu_state_pkg::op_wr_status, cpu_state_pkg::ctrl_isp, 32'h0f01_0000);
        irq(4'hf, 1'b0, 1'b0);
        op(cpu_state_pkg::op_wr_status, cpu_state_pkg::ctrl_isp, 32'h0201_0000);
        op(cpu_state_pkg::op_wait, cpu_state_pkg::ctrl_isp, 32'h0);
        chk1(waiting, 1'b1);
        op_valid = 1'b0;
        nmi_req = 1'b1;
        flags_update = 1'b1;
        next_flags_in = 4'h9;
        #1;
        chk1(nmi_ack, 1'b1);
        step();
        nmi_req = 1'b0;
        flags_update = 1'b0;
        chk32(status_word, sw(4'hf, 1'b0, 1'b0, 1'b0, 4'h9));
        chk1(waiting, 1'b0);
        chk32({30'h0, exc_cause}, 32'h1);
        v = rnd();
        op(cpu_state_pkg::op_wr_ctrl, cpu_state_pkg::ctrl_fast_irq_vector, v);
        op(cpu_state_pkg::op_wr_status, cpu_state_pkg::ctrl_isp, 32'h0101_0005);
        pc = rnd();
        irq(4'h9, 1'b1, 1'b1);
        chk32(fast_saved_pc, pc);
        chk32(fast_saved_status, sw(4'h1, 1'b0, 1'b0, 1'b1, 4'h5));
        chk32(exc_saved_status, sw(4'h1, 1'b0, 1'b0, 1'b1, 4'h5));
        chk32(branch_addr, v);
        op(cpu_state_pkg::op_wr_ctrl, cpu_state_pkg::ctrl_fast_saved_status, 32'h0510_0006);
        op(cpu_state_pkg::op_fast_return, cpu_state_pkg::ctrl_isp, 32'h0);
        chk32(branch_addr, pc);
        chk32(status_word, sw(4'h5, 1'b1, 1'b1, 1'b0, 4'h6));
        a = rnd();
        op(cpu_state_pkg::op_wr_ctrl, cpu_state_pkg::ctrl_isp, a);
        op(cpu_state_pkg::op_wr_ctrl, cpu_state_pkg::ctrl_vector_base_reg, a);
        op(cpu_state_pkg::op_wr_ctrl, cpu_state_pkg::ctrl_usp, a);
        op(cpu_state_pkg::op_wr_status, cpu_state_pkg::ctrl_isp, 32'h0f01_0003);
        chk32(irq_stack_ptr, 32'h0);
        chk32(vector_base_reg, 32'h0);
        chk32(active_sp, a);
        chk32(status_word, sw(4'h5, 1'b1, 1'b1, 1'b0, 4'h3));
        for (int i = 0; i < 4; i++) begin
            op_valid = 1'b1;
            op_code = pr[i];
            op_data = 32'h0f00_0000;
            #1;
            chk1(priv_fault, 1'b1);
            step();
            chk32({30'h0, exc_cause}, 32'h2);
            chk32(status_word, sw(4'h5, 1'b0, 1'b0, 1'b0, 4'h3));
            chk32(exc_saved_status, sw(4'h5, 1'b1, 1'b1, 1'b0, 4'h3));
            op(cpu_state_pkg::op_exc_return, cpu_state_pkg::ctrl_isp, sw(4'h5, 1'b1, 1'b0, 1'b0, 4'h3));
            chk32(status_word, sw(4'h5, 1'b1, 1'b1, 1'b0, 4'h3));
        end
        op_valid = 1'b0;
        sync_exc_req = 1'b1;
        step();
        sync_exc_req = 1'b0;
        chk32({30'h0, exc_cause}, 32'h2);
        chk32(status_word, sw(4'h5, 1'b0, 1'b0, 1'b0, 4'h3));
        do_reset(1'b1);
        lanes(1'b1);
        wrap_up();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        n_fail++;
        wrap_up();
    end
endmodule : tb_top
